/* File: shared/dac_mode_consts.svh */
// constants for the dac mode-control register bank
// included by the register bank module
`ifndef DAC_MODE_CONSTS_SVH
`define DAC_MODE_CONSTS_SVH

`define ADDR_RESET_MUTE_RATE   7'h40
`define ADDR_POWER_FORMAT      7'h41
`define ADDR_PAIR_DISABLE      7'h42
`define ADDR_PHASE_INVERT      7'h43
`define ADDR_SOFT_MUTE         7'h44

`define BIT_DEFAULTS_RESET     7
`define BIT_RESYNC_RESET       6
`define BIT_POWER_SAVE_POLICY  7

// data bit fields of the mode registers
`define FLD_MUTE_SOURCES       5:2
`define FLD_RATE_MODE          1:0
`define FLD_FORMAT             3:0
`define FLD_PAIR_DISABLE       7:4
`define FLD_ROLLOFF            3:0

`define DEF_MUTE_SOURCES       4'h0
`define DEF_RATE_MODE          2'h0
`define DEF_POWER_SAVE_POLICY  1'b0
`define DEF_FORMAT             4'h0
`define DEF_PAIR_DISABLE       4'h0
`define DEF_ROLLOFF            4'h0
`define DEF_PHASE_INVERT       8'h00
`define DEF_SOFT_MUTE          8'h00
`define UNMAPPED_READ          8'h00

// system clocks per sample: below the first bound quad, below second dual
`define RATIO_QUAD_LIMIT       11'd224
`define RATIO_DUAL_LIMIT       11'd448
`define RATIO_COUNT_MAX        11'h7FF

// soft mute steps when the sample count reaches this value, once every eight sample periods
`define RAMP_SAMPLES           3'd7
`define GAIN_FULL              8'hFF
`define GAIN_MUTED             8'h00

`endif

/* File: shared/dac_mode_pkg.sv */
// types for the dac mode-control register bank
// constants themselves live in dac_mode_consts.svh
package dac_mode_pkg;

    typedef enum logic [1:0] {
        RATE_AUTO   = 2'b00,
        RATE_SINGLE = 2'b01,
        RATE_DUAL   = 2'b10,
        RATE_QUAD   = 2'b11
    } rate_e;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_req_s;

    typedef struct packed {
        logic [3:0] disconnect;
        logic [3:0] powerDown;
        logic [3:0] commonMode;
        logic [3:0] ground;
        logic [3:0] slowRolloff;
    } pair_ctl_s;

endpackage

/* File: tb/dac_mode_control_registers_properties.sv */
// assertions on the mode-control register bank ports
// bound into every instance of the bank
`timescale 1ns/1ps
module dac_mode_control_registers_properties (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire dac_mode_pkg::reg_req_s  regReq,
    input wire logic                    regRdValid,
    input wire logic                    systemResync,
    input wire dac_mode_pkg::rate_e     activeRate,
    input wire logic [3:0]              audioFormat,
    input wire dac_mode_pkg::pair_ctl_s pairCtl,
    input wire logic [7:0]              phaseInvert,
    input wire logic [63:0]             channelGain
);
    import dac_mode_pkg::*;
    wire w40 = regReq.write && regReq.addr == 7'h40;
    wire w41 = regReq.write && regReq.addr == 7'h41;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_read_answer: assert property (regReq.read |=> regRdValid)
        else $error("read not answered");
    a_resync_pulse: assert property (w40 && !regReq.data[6] |=>
        systemResync) else $error("resync pulse missing");
    a_resync_cause: assert property (systemResync |->
        $past(w40) && !$past(regReq.data[6])) else $error("stray resync");
    a_defaults_back: assert property (w40 && !regReq.data[7] |=>
        ##1 pairCtl == '0 && phaseInvert == 8'h00 && audioFormat == 4'h0)
        else $error("defaults not restored");
    a_pair_policy: assert property ((pairCtl.commonMode &
        pairCtl.ground) == 4'h0 && pairCtl.ground == pairCtl.powerDown &&
        pairCtl.disconnect == (pairCtl.commonMode | pairCtl.ground))
        else $error("pair control mix wrong");
    a_rate_manual: assert property (w40 && regReq.data[7] &&
        regReq.data[1:0] != 2'b00 |=> ##1
        activeRate == $past(regReq.data[1:0], 2)) else $error("rate wrong");
    a_format_copy: assert property (w41 |=> ##1
        audioFormat == $past(regReq.data[3:0], 2)) else $error("format");
    a_gain_step: assert property ($changed(channelGain[7:0]) |->
        channelGain[7:0] - $past(channelGain[7:0]) inside {8'h01, 8'hFF})
        else $error("gain jumped");
endmodule
bind dac_mode_control_registers dac_mode_control_registers_properties
    u_props (.clk, .reset_n, .regReq, .regRdValid, .systemResync,
             .activeRate, .audioFormat, .pairCtl, .phaseInvert,
             .channelGain);

/* File: tb/dac_mode_control_registers_tb_top.sv */
// self-checking bench for the mode-control register bank
// host model drives requests; sampling clock made here
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
    err_total++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module dac_mode_control_registers_tb_top;
    import dac_mode_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        samplingClockPin = 1'b0;
    logic        clockHaltPin = 1'b0;
    logic        asyncDetectPin = 1'b0;
    logic        firstZeroFlag = 1'b0;
    logic        secondZeroFlag = 1'b0;
    reg_req_s    regReq;
    logic [7:0]  regRdData;
    logic        regRdValid;
    logic        systemResync;
    logic        analogMute;
    rate_e       activeRate;
    logic [3:0]  audioFormat;
    pair_ctl_s   pairCtl;
    logic [7:0]  phaseInvert;
    logic [7:0]  rd8;
    logic [63:0] channelGain;
    int          err_total = 0;
    int          samples_checked = 0;
    int          fsHalf = 256;
    int          fsCnt = 0;
    int          cycles = 0;
    int          resyncs = 0;
    always #10 clk = ~clk;
    dac_mode_control_registers u_dut (.clk, .reset_n, .regReq,
        .samplingClockPin, .clockHaltPin, .asyncDetectPin, .firstZeroFlag,
        .secondZeroFlag, .regRdData, .regRdValid, .systemResync,
        .activeRate, .audioFormat, .pairCtl, .phaseInvert, .analogMute,
        .channelGain);
    host_port_model u_host (.clk, .regReq, .regRdData, .regRdValid);
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (systemResync === 1'b1) resyncs++;
        if (fsCnt >= fsHalf - 1) begin
            fsCnt <= 0;
            samplingClockPin <= ~samplingClockPin;
        end else begin
            fsCnt <= fsCnt + 1;
        end
        if (cycles == 60000) begin
            err_total++;
            wrap_up;
        end
    end
    task automatic rdc(string nm, logic [6:0] a, logic [7:0] ex);
        u_host.rd(a, rd8);
        `CHK(nm, ex, rd8)
    endtask
    task automatic setSrc(int i, logic v);
        @(posedge clk);
        case (i)
            0: clockHaltPin <= v;
            1: asyncDetectPin <= v;
            2: begin
                firstZeroFlag <= v;
                secondZeroFlag <= v;
            end
            default: u_host.wr(7'h42, {3'b000, v, 4'h0});
        endcase
    endtask
    task automatic waitGain(logic [7:0] ex);
        for (int n = 0; n < 1500 && channelGain[7:0] !== ex; n++)
            @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rdc("r40", 7'h40, 8'hC0);
        rdc("r41", 7'h41, 8'h00);
        rdc("r42", 7'h42, 8'h00);
        rdc("r43", 7'h43, 8'h00);
        rdc("r45", 7'h45, 8'h00);
        for (int i = 0; i < 10; i++) begin
            u_host.wr(7'h41, {i[0], 3'b000, i[3:0]});
            rdc("r41", 7'h41, {i[0], 3'b000, i[3:0]});
            `CHK("fmt", i[3:0], audioFormat)
        end
        u_host.wr(7'h41, 8'h00);
        u_host.wr(7'h42, 8'h5A);
        rdc("r42", 7'h42, 8'h5A);
        `CHK("psave", 20'h5505A, pairCtl)
        u_host.wr(7'h41, 8'h80);
        rdc("r41", 7'h41, 8'h80);
        `CHK("vcm", 20'h5050A, pairCtl)
        u_host.wr(7'h43, 8'h81);
        rdc("r43", 7'h43, 8'h81);
        `CHK("phase", 8'h81, phaseInvert)
        for (int r = 1; r < 4; r++) begin
            u_host.wr(7'h40, {6'b110000, r[1:0]});
            repeat (2) @(posedge clk);
            `CHK("rate", r[1:0], activeRate)
        end
        u_host.wr(7'h40, 8'hC0);
        for (int k = 0; k < 3; k++) begin
            fsHalf = 64 << k;
            repeat (1200) @(posedge clk);
            `CHK("auto", 2'(3 - k), activeRate)
        end
        u_host.wrrd(7'h40, 8'h8D, rd8);
        `CHK("act", 8'h8D, rd8)
        rdc("back", 7'h40, 8'hCD);
        `CHK("resyncs", 1, resyncs)
        `CHK("keep", 8'h81, phaseInvert)
        `CHK("keeppc", 20'h5050A, pairCtl)
        u_host.wrrd(7'h40, 8'h7F, rd8);
        `CHK("dflt", 8'h40, rd8)
        rdc("r40", 7'h40, 8'hC0);
        rdc("r42", 7'h42, 8'h00);
        `CHK("dphase", 8'h00, phaseInvert)
        for (int i = 0; i < 4; i++) begin
            u_host.wr(7'h40, 8'hC0 | (8'h04 << i));
            setSrc(i, 1'b1);
            repeat (6) @(posedge clk);
            `CHK("analog_mute_source_enables", 1'b1, analogMute)
            setSrc(i, 1'b0);
            repeat (6) @(posedge clk);
            `CHK("aclear", 1'b0, analogMute)
        end
        fsHalf = 64;
        u_host.wr(7'h44, 8'h01);
        waitGain(8'hFE);
        `CHK("gain0", 8'hFE, channelGain[7:0])
        `CHK("gain1", 8'hFF, channelGain[15:8])
        u_host.wr(7'h44, 8'h00);
        waitGain(8'hFF);
        `CHK("gainup", 8'hFF, channelGain[7:0])
        wrap_up;
    end
endmodule

/* File: tb/host_port_model.sv */
// host side of the serial control port: one-cycle requests
// assumes the bank takes requests on the rising clk edge
`timescale 1ns/1ps
module host_port_model (
    input  wire logic                   clk,
    output dac_mode_pkg::reg_req_s      regReq,
    input  wire logic [7:0]             regRdData,
    input  wire logic                   regRdValid
);
    import dac_mode_pkg::*;
    initial regReq = '0;
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        regReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic wrrd(input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
        repeat (4) begin
            @(posedge clk);
            if (regRdValid === 1'b1) break;
        end
        q = regRdData;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
        repeat (4) begin
            @(posedge clk);
            if (regRdValid === 1'b1) break;
        end
        d = regRdData;
    endtask
endmodule

/* File: verilog/dac_mode_control_registers.sv */
// mode-control register bank of an eight-channel audio dac
// assumes a serial port decoder on clk issuing one-cycle requests
`timescale 1ns/1ps
`include "dac_mode_consts.svh"

module dac_mode_control_registers (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire dac_mode_pkg::reg_req_s regReq,
    input  wire logic                  samplingClockPin,
    input  wire logic                  clockHaltPin,
    input  wire logic                  asyncDetectPin,
    input  wire logic                  firstZeroFlag,
    input  wire logic                  secondZeroFlag,
    output logic [7:0]                 regRdData,
    output logic                       regRdValid,
    output logic                       systemResync,
    output dac_mode_pkg::rate_e        activeRate,
    output logic [3:0]                 audioFormat,
    output dac_mode_pkg::pair_ctl_s    pairCtl,
    output logic [7:0]                 phaseInvert,
    output logic                       analogMute,
    output logic [63:0]                channelGain
);
    import dac_mode_pkg::*;

    // stored fields
    logic [3:0] muteSources;
    rate_e      rateMode;
    logic       powerSavePolicy;
    logic [3:0] formatCode;
    logic [3:0] pairDisable;
    logic [3:0] rolloff;
    logic [7:0] phaseBits;
    logic [7:0] softMute;

    // self-clearing reset bits
    logic       defaultsBit;
    logic       resyncBit;

    // decoded request
    logic       writeHit40;
    logic       writeHit41;
    logic       writeHit42;
    logic       writeHit43;
    logic       writeHit44;
    logic       defaultsAction;
    logic       resyncAction;

    assign writeHit40 = regReq.write && regReq.addr == `ADDR_RESET_MUTE_RATE;
    assign writeHit41 = regReq.write && regReq.addr == `ADDR_POWER_FORMAT;
    assign writeHit42 = regReq.write && regReq.addr == `ADDR_PAIR_DISABLE;
    assign writeHit43 = regReq.write && regReq.addr == `ADDR_PHASE_INVERT;
    assign writeHit44 = regReq.write && regReq.addr == `ADDR_SOFT_MUTE;
    assign defaultsAction = writeHit40 && !regReq.data[`BIT_DEFAULTS_RESET];
    assign resyncAction   = writeHit40 && !regReq.data[`BIT_RESYNC_RESET];

    // reset bits drop for exactly one cycle, then read 1 again
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            defaultsBit <= 1'b1;
        end else begin
            defaultsBit <= !defaultsAction;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resyncBit <= 1'b1;
        end else begin
            resyncBit <= !resyncAction;
        end
    end

    // register 0x40 fields
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            muteSources <= `DEF_MUTE_SOURCES;
            rateMode    <= rate_e'(`DEF_RATE_MODE);
        end else if (defaultsAction) begin
            muteSources <= `DEF_MUTE_SOURCES;
            rateMode    <= rate_e'(`DEF_RATE_MODE);
        end else if (writeHit40) begin
            muteSources <= regReq.data[`FLD_MUTE_SOURCES];
            rateMode    <= rate_e'(regReq.data[`FLD_RATE_MODE]);
        end
    end

    // register 0x41 fields, reserved bits dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            powerSavePolicy <= `DEF_POWER_SAVE_POLICY;
            formatCode      <= `DEF_FORMAT;
        end else if (defaultsAction) begin
            powerSavePolicy <= `DEF_POWER_SAVE_POLICY;
            formatCode      <= `DEF_FORMAT;
        end else if (writeHit41) begin
            powerSavePolicy <= regReq.data[`BIT_POWER_SAVE_POLICY];
            formatCode      <= regReq.data[`FLD_FORMAT];
        end
    end

    // register 0x42 fields
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pairDisable <= `DEF_PAIR_DISABLE;
            rolloff     <= `DEF_ROLLOFF;
        end else if (defaultsAction) begin
            pairDisable <= `DEF_PAIR_DISABLE;
            rolloff     <= `DEF_ROLLOFF;
        end else if (writeHit42) begin
            pairDisable <= regReq.data[`FLD_PAIR_DISABLE];
            rolloff     <= regReq.data[`FLD_ROLLOFF];
        end
    end

    // register 0x43
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phaseBits <= `DEF_PHASE_INVERT;
        end else if (defaultsAction) begin
            phaseBits <= `DEF_PHASE_INVERT;
        end else if (writeHit43) begin
            phaseBits <= regReq.data;
        end
    end

    // register 0x44
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            softMute <= `DEF_SOFT_MUTE;
        end else if (defaultsAction) begin
            softMute <= `DEF_SOFT_MUTE;
        end else if (writeHit44) begin
            softMute <= regReq.data;
        end
    end

    // read port, independent of pair disable state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData  <= `UNMAPPED_READ;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regReq.read;
            if (regReq.read) begin
                case (regReq.addr)
                    `ADDR_RESET_MUTE_RATE: begin
                        regRdData <= {defaultsBit, resyncBit,
                                      muteSources, rateMode};
                    end
                    `ADDR_POWER_FORMAT: begin
                        regRdData <= {powerSavePolicy, 3'h0, formatCode};
                    end
                    `ADDR_PAIR_DISABLE: begin
                        regRdData <= {pairDisable, rolloff};
                    end
                    `ADDR_PHASE_INVERT: begin
                        regRdData <= phaseBits;
                    end
                    `ADDR_SOFT_MUTE: begin
                        regRdData <= softMute;
                    end
                    default: begin
                        regRdData <= `UNMAPPED_READ;
                    end
                endcase
            end
        end
    end

    // pin synchronisers
    logic [4:0] pinMeta;
    logic [4:0] pinSync;
    logic       samplePrev;
    logic       sampleEdge;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta    <= 5'h00;
            pinSync    <= 5'h00;
            samplePrev <= 1'b0;
        end else begin
            pinMeta    <= {samplingClockPin, clockHaltPin,
                           asyncDetectPin, firstZeroFlag, secondZeroFlag};
            pinSync    <= pinMeta;
            samplePrev <= pinSync[4];
        end
    end

    assign sampleEdge = pinSync[4] && !samplePrev;

    // system clocks per sample period, restarted by resync
    logic [10:0] periodCount;
    rate_e       measuredRate;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            periodCount  <= 11'h000;
            measuredRate <= RATE_SINGLE;
        end else if (resyncAction) begin
            periodCount  <= 11'h000;
        end else if (sampleEdge) begin
            periodCount <= 11'h001;
            if (periodCount < `RATIO_QUAD_LIMIT) begin
                measuredRate <= RATE_QUAD;
            end else if (periodCount < `RATIO_DUAL_LIMIT) begin
                measuredRate <= RATE_DUAL;
            end else begin
                measuredRate <= RATE_SINGLE;
            end
        end else if (periodCount != `RATIO_COUNT_MAX) begin
            periodCount <= periodCount + 11'h001;
        end
    end

    // resync pulse out, no power-down involved
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            systemResync <= 1'b0;
        end else begin
            systemResync <= resyncAction;
        end
    end

    // rate applied: manual field or measured ratio
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            activeRate <= RATE_SINGLE;
        end else if (rateMode == RATE_AUTO) begin
            activeRate <= measuredRate;
        end else begin
            activeRate <= rateMode;
        end
    end

    // format code out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            audioFormat <= `DEF_FORMAT;
        end else begin
            audioFormat <= formatCode;
        end
    end

    // phase selection out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phaseInvert <= `DEF_PHASE_INVERT;
        end else begin
            phaseInvert <= phaseBits;
        end
    end

    // disabled pairs split by power-save policy
    logic [3:0] toCommonMode;
    logic [3:0] toGround;

    assign toCommonMode = pairDisable & {4{powerSavePolicy}};
    assign toGround     = pairDisable & {4{!powerSavePolicy}};

    // per-pair disable handling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pairCtl <= '0;
        end else begin
            pairCtl.disconnect  <= pairDisable;
            pairCtl.commonMode  <= toCommonMode;
            pairCtl.ground      <= toGround;
            pairCtl.powerDown   <= toGround;
            pairCtl.slowRolloff <= rolloff;
        end
    end

    // a source mutes only when its enable bit is set
    logic [3:0] muteCause;

    assign muteCause = muteSources & {|pairDisable, pinSync[1] & pinSync[0],
                                      pinSync[2], pinSync[3]};

    // analog mute from enabled sources
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            analogMute <= 1'b0;
        end else begin
            analogMute <= |muteCause;
        end
    end

    // soft mute ramp, one step every eight samples
    logic [2:0] rampCount;
    logic       rampTick;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rampCount <= 3'h0;
            rampTick  <= 1'b0;
        end else begin
            rampTick <= sampleEdge && rampCount == `RAMP_SAMPLES;
            if (sampleEdge) begin
                rampCount <= rampCount + 3'h1;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 8; ch = ch + 1) begin : gainRamp
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    channelGain[ch*8 +: 8] <= `GAIN_FULL;
                end else if (rampTick) begin
                    if (softMute[ch]) begin
                        if (channelGain[ch*8 +: 8] != `GAIN_MUTED) begin
                            channelGain[ch*8 +: 8] <=
                                channelGain[ch*8 +: 8] - 8'h01;
                        end
                    end else if (channelGain[ch*8 +: 8] != `GAIN_FULL) begin
                        channelGain[ch*8 +: 8] <=
                            channelGain[ch*8 +: 8] + 8'h01;
                    end
                end
            end
        end
    endgenerate

endmodule
